// *** hdl/cocr_regs.vh ***
// Offsets, field positions and reset values of the clock output control bytes
`ifndef COCR_REGS_VH
`define COCR_REGS_VH

// Byte offsets as seen on the command-byte port
`define COCR_OFF_PCI_EN       8'h02
`define COCR_OFF_AGP_PERIPH   8'h03
`define COCR_OFF_STRENGTH     8'h04
`define COCR_OFF_DDR_CTRL     8'h05
`define COCR_OFF_RESERVED     8'h06
`define COCR_OFF_DIVIDER_N    8'h07

// Power-up defaults
`define COCR_RST_PCI_EN       8'h7F
`define COCR_RST_AGP_PERIPH   8'h67
`define COCR_RST_STRENGTH     8'hCF
`define COCR_RST_DDR_CTRL     8'h7F
`define COCR_RST_RESERVED     8'h80
`define COCR_RST_DIVIDER_N    8'h00

// Byte 2 fields
`define COCR_PCI_STRONG_BIT   7
`define COCR_PCI_FREE_BIT     6
`define COCR_PCI_EN_MSB       4
`define COCR_PCI_EN_LSB       0

// Byte 3 fields
`define COCR_DUAL_RATE_48_BIT 7
`define COCR_USB_EN_BIT       6
`define COCR_DUAL_EN_BIT      5
`define COCR_SKEW_MSB         4
`define COCR_SKEW_LSB         3
`define COCR_GFX_B_EN_BIT     1
`define COCR_GFX_A_EN_BIT     0

// Byte 4 fields
`define COCR_USB_STR_BIT      7
`define COCR_DUAL_STR_BIT     6
`define COCR_RATIO_MSB        5
`define COCR_RATIO_LSB        4
`define COCR_REF_A_EN_BIT     3
`define COCR_REF_B_EN_BIT     2
`define COCR_REF_A_STR_BIT    1
`define COCR_REF_B_STR_BIT    0

// Byte 5 fields
`define COCR_THRESH_BIT       7
`define COCR_FB_EN_BIT        6
`define COCR_MEM_EN_MSB       5
`define COCR_MEM_EN_LSB       0

// Byte 7 fields
`define COCR_TEST_BIT         7
`define COCR_DIV_N_MSB        6
`define COCR_DIV_N_LSB        0

// Width of the registered output vector
`define COCR_OUT_W            40

`endif

// *** hdl/cocr_sync.v ***
// Two-flop synchroniser for levels arriving from pins
`timescale 1ns/1ps
module cocr_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rstn,
  input  wire         ce,
  input  wire [W-1:0] asyncIn,
  output wire [W-1:0] syncOut
);

  reg [W-1:0] stage1_reg;
  reg [W-1:0] stage2_reg;

  // First stage feeds only the second stage
  always @(posedge clk) begin
    if (!rstn) begin
      stage1_reg <= {W{1'b0}};
      stage2_reg <= {W{1'b0}};
    end else if (ce) begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;

endmodule

// *** hdl/cocr_out_stage.v ***
// Per-bit registered output stage with its own reset value
`timescale 1ns/1ps
module cocr_out_stage #(
  parameter W         = 8,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input  wire         clk,
  input  wire         rstn,
  input  wire         ce,
  input  wire [W-1:0] dIn,
  output wire [W-1:0] qOut
);

  genvar i;

  // One flop per control line
  generate
    for (i = 0; i < W; i = i + 1) begin : gBit
      reg bit_reg;
      always @(posedge clk) begin
        if (!rstn) begin
          bit_reg <= RST[i];
        end else if (ce) begin
          bit_reg <= dIn[i];
        end
      end
      assign qOut[i] = bit_reg;
    end
  endgenerate

endmodule

// *** hdl/cocr_top.v ***
// Clock output control register bank with registered control outputs
//
// Summary of operation
// - Enable bit 1 runs its output; 0 stops it low, both legs of pairs.
// - Dual-rate output defaults to 24 MHz; writing 1 selects 48 MHz at once.
// - USB and dual-rate strength bits: 1 single drive, 0 double drive.
// - First reference strength bit: 1 single drive, 0 double drive.
// - Second reference enable and strength act only in alternate processor mode.
// - Two-bit skew code shifts all graphics outputs: default, -280, +280, +480 ps.
// - Two-bit ratio code: frequency default, 2/1, 2.5/1 or 3/1.
// - Ratio override applies jointly to graphics and all PCI outputs.
// - Threshold bit in memory mode: 0 selects 1.15 V, 1 selects 1.05 V.
// - Bits 6 to 0 hold the feedback divider N, bit 6 most significant.
// - Retuning N leaves every derived clock ratio to the CPU clock unchanged.
// - Divider byte top bit is a test bit with no normal function.
// - Host divider used only when source select is 1, else table values.
`timescale 1ns/1ps
`include "cocr_regs.vh"
module cocr_top (
  input  wire       clk,
  input  wire       rstn,
  input  wire       ce,
  // Byte port from the serial engine, same clock
  input  wire       wrEn,
  input  wire       rdEn,
  input  wire [7:0] regAddr,
  input  wire [7:0] wrData,
  output wire [7:0] rdData,
  output wire       rdValid,
  // Mode strap and divider source, strap from a pin
  input  wire       alternateProcessorMode,
  input  wire       divider_source_sel,
  input  wire [6:0] romDividerN,
  // Control outputs: enables, drive strengths, selects, skew, ratios, threshold and divider
  output wire [4:0] pciOutEnable,
  output wire       pciFreeEnable,
  output wire       pciStrongDrive,
  output wire       fixedUsbClockEnable,
  output wire       dualRatePeriphEnable,
  output wire       dualRateSel48,
  output wire [1:0] graphicsClkEnable,
  output wire [1:0] agpSkewSel,
  output wire       fixedUsbDoubleDrive,
  output wire       dualRateDoubleDrive,
  output wire [1:0] agpRatioSel,
  output wire [1:0] pciRatioSel,
  output wire       refClockAEnable,
  output wire       refClockBEnable,
  output wire       refClockADoubleDrive,
  output wire       refClockBDoubleDrive,
  output wire       bufThresholdLow,
  output wire       feedbackClockEnable,
  output wire [5:0] memPairEnable,
  output wire [6:0] pllDividerN
);

  // Stored bytes
  reg  [7:0]  pciEn_reg;
  reg  [7:0]  agpPeriph_reg;
  reg  [7:0]  strength_reg;
  reg  [7:0]  ddrCtrl_reg;
  reg  [7:0]  dividerN_reg;
  reg  [7:0]  rdData_reg;
  reg  [7:0]  rdData_next;
  reg         rdValid_reg;

  wire        altModeSync;
  wire [`COCR_OUT_W-1:0] ctrlNext;
  wire [`COCR_OUT_W-1:0] ctrlQ;
  wire        refBEnEff;
  wire        refBStrEff;
  wire [6:0]  dividerNEff;
  wire [1:0]  ratioCode;
  wire [4:0]  pciOutEn_next;
  wire        pciFreeEn_next;
  wire        pciStrong_next;
  wire        usbEn_next;
  wire        dualEn_next;
  wire        dualSel48_next;
  wire [1:0]  gfxEn_next;
  wire [1:0]  skew_next;
  wire        usbDouble_next;
  wire        dualDouble_next;
  wire        refAEn_next;
  wire        refADouble_next;
  wire        threshLow_next;
  wire        fbEn_next;
  wire [5:0]  memEn_next;

  // output reset image
  // Built from the byte defaults so pins and registers agree in reset
  localparam [7:0] PCI_EN_DFLT = `COCR_RST_PCI_EN;
  localparam [7:0] AGP_DFLT    = `COCR_RST_AGP_PERIPH;
  localparam [7:0] STR_DFLT    = `COCR_RST_STRENGTH;
  localparam [7:0] DDR_DFLT    = `COCR_RST_DDR_CTRL;
  localparam [7:0] DIV_DFLT    = `COCR_RST_DIVIDER_N;
  localparam [`COCR_OUT_W-1:0] OUT_RST = {
    PCI_EN_DFLT[`COCR_PCI_EN_MSB:`COCR_PCI_EN_LSB],
    PCI_EN_DFLT[`COCR_PCI_FREE_BIT],
    PCI_EN_DFLT[`COCR_PCI_STRONG_BIT],
    AGP_DFLT[`COCR_USB_EN_BIT],
    AGP_DFLT[`COCR_DUAL_EN_BIT],
    AGP_DFLT[`COCR_DUAL_RATE_48_BIT],
    AGP_DFLT[`COCR_GFX_B_EN_BIT],
    AGP_DFLT[`COCR_GFX_A_EN_BIT],
    AGP_DFLT[`COCR_SKEW_MSB:`COCR_SKEW_LSB],
    ~STR_DFLT[`COCR_USB_STR_BIT],
    ~STR_DFLT[`COCR_DUAL_STR_BIT],
    STR_DFLT[`COCR_RATIO_MSB:`COCR_RATIO_LSB],
    STR_DFLT[`COCR_RATIO_MSB:`COCR_RATIO_LSB],
    STR_DFLT[`COCR_REF_A_EN_BIT],
    1'b0,                                          // Second reference off before strap
    ~STR_DFLT[`COCR_REF_A_STR_BIT],
    1'b0,                                          // Second reference single drive
    DDR_DFLT[`COCR_THRESH_BIT],
    DDR_DFLT[`COCR_FB_EN_BIT],
    DDR_DFLT[`COCR_MEM_EN_MSB:`COCR_MEM_EN_LSB],
    1'b0,
    DIV_DFLT[`COCR_DIV_N_MSB:`COCR_DIV_N_LSB]
  };

  // Strap comes from a pin, so it is synchronised first
  cocr_sync #(
    .W (1)
  ) uStrapSync (
    .clk     (clk),
    .rstn    (rstn),
    .ce      (ce),
    .asyncIn (alternateProcessorMode),
    .syncOut (altModeSync)
  );

  // load defaults
  // Register writes; byte 6 has no storage
  always @(posedge clk) begin
    if (!rstn) begin
      pciEn_reg     <= `COCR_RST_PCI_EN;
      agpPeriph_reg <= `COCR_RST_AGP_PERIPH;
      strength_reg  <= `COCR_RST_STRENGTH;
      ddrCtrl_reg   <= `COCR_RST_DDR_CTRL;
      dividerN_reg  <= `COCR_RST_DIVIDER_N;
    end else if (ce && wrEn) begin
      if (regAddr == `COCR_OFF_PCI_EN) begin
        pciEn_reg <= wrData;
      end else if (regAddr == `COCR_OFF_AGP_PERIPH) begin
        agpPeriph_reg <= wrData;
      end else if (regAddr == `COCR_OFF_STRENGTH) begin
        strength_reg <= wrData;
      end else if (regAddr == `COCR_OFF_DDR_CTRL) begin
        ddrCtrl_reg <= wrData;
      end else if (regAddr == `COCR_OFF_DIVIDER_N) begin
        dividerN_reg <= wrData;
      end
    end
  end

  // read back
  // Read mux; unmapped offsets return zero
  always @* begin
    rdData_next = 8'h00;
    if (regAddr == `COCR_OFF_PCI_EN) begin
      rdData_next = pciEn_reg;
    end else if (regAddr == `COCR_OFF_AGP_PERIPH) begin
      rdData_next = agpPeriph_reg;
    end else if (regAddr == `COCR_OFF_STRENGTH) begin
      rdData_next = strength_reg;
    end else if (regAddr == `COCR_OFF_DDR_CTRL) begin
      rdData_next = ddrCtrl_reg;
    end else if (regAddr == `COCR_OFF_RESERVED) begin
      rdData_next = `COCR_RST_RESERVED;
    end else if (regAddr == `COCR_OFF_DIVIDER_N) begin
      rdData_next = dividerN_reg;
    end
  end

  // Read data held until the next read
  always @(posedge clk) begin
    if (!rstn) begin
      rdData_reg  <= 8'h00;
      rdValid_reg <= 1'b0;
    end else if (ce) begin
      rdValid_reg <= rdEn;
      if (rdEn) begin
        rdData_reg <= rdData_next;
      end
    end
  end

  assign rdData  = rdData_reg;
  assign rdValid = rdValid_reg;

  // alternate mode gate
  // Second reference is off and single drive outside alternate mode
  assign refBEnEff  = altModeSync & strength_reg[`COCR_REF_B_EN_BIT];
  assign refBStrEff = altModeSync & ~strength_reg[`COCR_REF_B_STR_BIT];

  // divider source
  // Host divider only when the source select is set
  assign dividerNEff = divider_source_sel ?
                       dividerN_reg[`COCR_DIV_N_MSB:`COCR_DIV_N_LSB] : romDividerN;

  // ratios independent of N
  // Ratio code never depends on the divider value
  assign ratioCode = strength_reg[`COCR_RATIO_MSB:`COCR_RATIO_LSB];

  // enable bits
  // Run or stop lines taken straight from the stored bytes
  assign pciOutEn_next  = pciEn_reg[`COCR_PCI_EN_MSB:`COCR_PCI_EN_LSB];
  assign pciFreeEn_next = pciEn_reg[`COCR_PCI_FREE_BIT];
  assign usbEn_next     = agpPeriph_reg[`COCR_USB_EN_BIT];
  assign dualEn_next    = agpPeriph_reg[`COCR_DUAL_EN_BIT];
  assign gfxEn_next     = {agpPeriph_reg[`COCR_GFX_B_EN_BIT], agpPeriph_reg[`COCR_GFX_A_EN_BIT]};
  assign refAEn_next    = strength_reg[`COCR_REF_A_EN_BIT];
  assign fbEn_next      = ddrCtrl_reg[`COCR_FB_EN_BIT];
  // One enable per memory pair covers both legs
  assign memEn_next     = ddrCtrl_reg[`COCR_MEM_EN_MSB:`COCR_MEM_EN_LSB];

  // PCI drive boost is a plain stored bit
  assign pciStrong_next = pciEn_reg[`COCR_PCI_STRONG_BIT];

  // rate select
  // Level goes out unsynchronised to the peripheral clock
  assign dualSel48_next = agpPeriph_reg[`COCR_DUAL_RATE_48_BIT];

  // skew code
  // One code shifts all graphics outputs together
  assign skew_next = agpPeriph_reg[`COCR_SKEW_MSB:`COCR_SKEW_LSB];

  // inverted strength
  // Stored 1 is single drive, so the double-drive lines invert
  assign usbDouble_next  = ~strength_reg[`COCR_USB_STR_BIT];
  assign dualDouble_next = ~strength_reg[`COCR_DUAL_STR_BIT];

  assign refADouble_next = ~strength_reg[`COCR_REF_A_STR_BIT];

  // threshold select
  // Exported in every mode; only memory mode applies it
  assign threshLow_next = ddrCtrl_reg[`COCR_THRESH_BIT];

  // Control vector handed to the output flops
  assign ctrlNext = {
    pciOutEn_next,                                     // 39:35
    pciFreeEn_next,                                    // 34
    pciStrong_next,                                    // 33
    usbEn_next,                                        // 32
    dualEn_next,                                       // 31
    dualSel48_next,                                    // 30
    gfxEn_next,                                        // 29:28
    skew_next,                                         // 27:26
    usbDouble_next,                                    // 25
    dualDouble_next,                                   // 24
    ratioCode,                                         // 23:22
    ratioCode,                                         // 21:20
    refAEn_next,                                       // 19
    refBEnEff,                                         // 18
    refADouble_next,                                   // 17
    refBStrEff,                                        // 16
    threshLow_next,                                    // 15
    fbEn_next,                                         // 14
    memEn_next,                                        // 13:8
    1'b0,                                              // 7 spare
    dividerNEff                                        // 6:0
  };

  // Registered outputs; reset value mirrors the register defaults
  cocr_out_stage #(
    .W   (`COCR_OUT_W),
    .RST (OUT_RST)
  ) uOutStage (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .dIn  (ctrlNext),
    .qOut (ctrlQ)
  );

  // Output fan-out
  assign pciOutEnable         = ctrlQ[39:35];
  assign pciFreeEnable        = ctrlQ[34];
  assign pciStrongDrive       = ctrlQ[33];
  assign fixedUsbClockEnable  = ctrlQ[32];
  assign dualRatePeriphEnable = ctrlQ[31];
  assign dualRateSel48        = ctrlQ[30];
  assign graphicsClkEnable    = ctrlQ[29:28];
  assign agpSkewSel           = ctrlQ[27:26];
  assign fixedUsbDoubleDrive  = ctrlQ[25];
  assign dualRateDoubleDrive  = ctrlQ[24];
  assign agpRatioSel          = ctrlQ[23:22];
  assign pciRatioSel          = ctrlQ[21:20];
  assign refClockAEnable      = ctrlQ[19];
  assign refClockBEnable      = ctrlQ[18];
  assign refClockADoubleDrive = ctrlQ[17];
  assign refClockBDoubleDrive = ctrlQ[16];
  assign bufThresholdLow      = ctrlQ[15];
  assign feedbackClockEnable  = ctrlQ[14];
  assign memPairEnable        = ctrlQ[13:8];
  assign pllDividerN          = ctrlQ[6:0];

endmodule

// *** verification/cocr_checker.sv ***
// Port assertions for the clock output control register bank
`timescale 1ns/1ps
module cocr_checker (
  input wire       clk,
  input wire       rstn,
  input wire       ce,
  input wire       wrEn,
  input wire       rdEn,
  input wire [7:0] regAddr,
  input wire [7:0] wrData,
  input wire [7:0] rdData,
  input wire       rdValid,
  input wire       alternateProcessorMode,
  input wire       divider_source_sel,
  input wire [6:0] romDividerN,
  input wire [4:0] pciOutEnable,
  input wire       dualRateSel48,
  input wire       fixedUsbDoubleDrive,
  input wire [1:0] agpRatioSel,
  input wire [1:0] pciRatioSel,
  input wire       refClockBEnable,
  input wire [6:0] pllDividerN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Written fields reach the pins two edges after the write
  a_pci_en_follow: assert property (
    ce && wrEn && regAddr == 8'h02 ##1 ce |=> pciOutEnable == $past(wrData[4:0], 2))
    else $error("pci enables do not follow write");
  a_dual_rate_sel: assert property (
    ce && wrEn && regAddr == 8'h03 ##1 ce |=> dualRateSel48 == $past(wrData[7], 2))
    else $error("rate select does not follow write");
  a_usb_strength: assert property (
    ce && wrEn && regAddr == 8'h04 ##1 ce |=> fixedUsbDoubleDrive == !$past(wrData[7], 2))
    else $error("usb strength does not follow write");
  a_ratio_follow: assert property (
    ce && wrEn && regAddr == 8'h04 ##1 ce |=> agpRatioSel == $past(wrData[5:4], 2))
    else $error("ratio code does not follow write");
  // Mode gating, joint ratio, divider source and read port
  a_refb_mode_gate: assert property (
    refClockBEnable |-> $past(alternateProcessorMode, 2) || $past(alternateProcessorMode, 3))
    else $error("second reference enabled outside mode");
  a_ratio_joint: assert property (agpRatioSel == pciRatioSel)
    else $error("graphics and pci ratio differ");
  a_div_source_sel: assert property (
    $past(rstn) && $past(ce) && !$past(divider_source_sel) |-> pllDividerN == $past(romDividerN))
    else $error("divider not taken from table");
  a_rd_valid_pulse: assert property ($past(rstn) && $past(ce) |-> rdValid == $past(rdEn))
    else $error("read valid not one cycle after strobe");
  a_rsvd_read: assert property (ce && rdEn && regAddr == 8'h06 |=> rdData == 8'h80)
    else $error("reserved byte pattern wrong");
endmodule
bind cocr_top cocr_checker u_chk (.*);

// *** verification/cocr_host.sv ***
// Host side model that writes and reads configuration bytes
`timescale 1ns/1ps
module cocr_host (
  input  wire       clk,
  input  wire [7:0] rdData,
  input  wire       rdValid,
  output reg        wrEn = 1'b0,
  output reg        rdEn = 1'b0,
  output reg  [7:0] regAddr = 8'h00,
  output reg  [7:0] wrData = 8'h00
);
  function [7:0] legal(input [7:0] a, input [7:0] d);
    legal = (a == 8'h02) ? d | 8'h20 : (a == 8'h03) ? d | 8'h04 : (a == 8'h07) ? d & 8'h7F : d;
  endfunction
  // One write strobe, then the bus shows a changed pattern
  task write_byte(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      wrEn <= 1'b1;
      regAddr <= a;
      wrData <= legal(a, d);
      @(posedge clk);
      wrEn <= 1'b0;
      regAddr <= ~a;
      wrData <= ~d;
    end
  endtask
  // One read strobe, data taken with the valid pulse
  task read_byte(input [7:0] a, output [7:0] d, output ok);
    integer i;
    begin
      ok = 1'b0;
      d = 8'h00;
      @(posedge clk);
      rdEn <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      rdEn <= 1'b0;
      regAddr <= ~a;
      for (i = 0; i < 4 && !ok; i = i + 1) begin
        #1;
        if (rdValid === 1'b1) begin
          d = rdData;
          ok = 1'b1;
        end else begin
          @(posedge clk);
        end
      end
    end
  endtask
endmodule

// *** verification/clock_output_control_regs_bench.sv ***
// Self-checking bench for the clock output control register bank
`timescale 1ns/1ps
module clock_output_control_regs_bench;
  localparam [47:0] DFLT = 48'h0080_7FCF_677F;
  reg        clk = 1'b0;
  reg        rstn = 1'b0;
  reg        ce = 1'b1;
  reg        alternateProcessorMode = 1'b0;
  reg        divider_source_sel = 1'b0;
  reg  [6:0] romDividerN = 7'h00;
  wire [7:0] regAddr, wrData, rdData;
  wire [6:0] pllDividerN;
  wire [5:0] memPairEnable;
  wire [4:0] pciOutEnable;
  wire [1:0] graphicsClkEnable, agpSkewSel, agpRatioSel, pciRatioSel;
  wire       wrEn, rdEn, rdValid, pciFreeEnable, pciStrongDrive, fixedUsbClockEnable;
  wire       dualRatePeriphEnable, dualRateSel48, fixedUsbDoubleDrive, dualRateDoubleDrive;
  wire       refClockAEnable, refClockBEnable, refClockADoubleDrive, refClockBDoubleDrive;
  wire       bufThresholdLow, feedbackClockEnable;
  integer    num_errors = 0;
  integer    num_checks = 0;
  integer    k;
  reg  [7:0] rd;
  reg        ok;
  cocr_top  dut (.*);
  cocr_host host (.*);
  initial forever #10 clk = ~clk;
  // Pins folded back into the register byte layout
  function [7:0] pins(input [7:0] a);
    case (a)
      8'h02: pins = {pciStrongDrive, pciFreeEnable, 1'b1, pciOutEnable};
      8'h03: pins = {dualRateSel48, fixedUsbClockEnable, dualRatePeriphEnable, agpSkewSel,
                     1'b1, graphicsClkEnable};
      8'h04: pins = {~fixedUsbDoubleDrive, ~dualRateDoubleDrive, agpRatioSel, refClockAEnable,
                     refClockBEnable, ~refClockADoubleDrive, ~refClockBDoubleDrive};
      8'h05: pins = {bufThresholdLow, feedbackClockEnable, memPairEnable};
      default: pins = {1'b0, pllDividerN};
    endcase
  endfunction
  // Second reference shows off and single drive outside the mode
  function [7:0] want(input [7:0] a, input [7:0] v);
    want = (a == 8'h04 && !alternateProcessorMode) ? {v[7:3], 1'b0, v[1], 1'b1} : v;
  endfunction
  task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("unexpected %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Read a byte under a bounded wait and compare
  task get(input [7:0] a, input [7:0] e);
    begin
      host.read_byte(a, rd, ok);
      if (!ok) begin
        num_errors = num_errors + 1;
        print_verdict;
      end
      chk("read", e, rd);
    end
  endtask
  // Write a byte, compare pins and read-back
  task put(input [7:0] a, input [7:0] v);
    begin
      host.write_byte(a, v);
      repeat (2) @(posedge clk);
      #1 chk("pins", want(a, v), pins(a));
      get(a, v);
    end
  endtask
  task t_defaults;
    begin
      for (k = 2; k < 8; k = k + 1) begin
        if (k != 6) chk("pins", want(k[7:0], DFLT[8*k-16 +: 8]), pins(k[7:0]));
        get(k[7:0], DFLT[8*k-16 +: 8]);
      end
      get(8'h01, 8'h00);
      $display("t_defaults done");
    end
  endtask
  task t_stop;
    begin
      put(8'h02, 8'h20);
      put(8'h03, 8'h04);
      put(8'h04, 8'hC7);
      put(8'h05, 8'h00);
      $display("t_stop done");
    end
  endtask
  task t_rate;
    begin
      put(8'h03, 8'hE7);
      put(8'h04, 8'h0C);
      put(8'h05, 8'hBF);
      $display("t_rate done");
    end
  endtask
  task t_codes;
    for (k = 0; k < 4; k = k + 1) begin
      put(8'h03, {3'b011, k[1:0], 3'b111});
      put(8'h04, {2'b11, k[1:0], 4'hF});
      chk("pci ratio", {6'h00, k[1:0]}, {6'h00, pciRatioSel});
    end
  endtask
  task t_mode;
    begin
      @(posedge clk);
      alternateProcessorMode <= 1'b1;
      repeat (4) @(posedge clk);
      put(8'h04, 8'hCE);
      @(posedge clk);
      alternateProcessorMode <= 1'b0;
      repeat (4) @(posedge clk);
      #1 chk("pins", want(8'h04, 8'hCE), pins(8'h04));
      $display("t_mode done");
    end
  endtask
  task t_div;
    begin
      @(posedge clk);
      divider_source_sel <= 1'b1;
      put(8'h07, 8'h40);
      put(8'h07, 8'h01);
      @(posedge clk);
      divider_source_sel <= 1'b0;
      romDividerN <= 7'h2A;
      repeat (2) @(posedge clk);
      #1 chk("divider", 8'h2A, pins(8'h07));
      get(8'h07, 8'h01);
      $display("t_div done");
    end
  endtask
  task t_rsvd;
    begin
      host.write_byte(8'h06, 8'h5A);
      host.write_byte(8'h09, 8'hFF);
      get(8'h06, 8'h80);
      get(8'h09, 8'h00);
      get(8'h05, 8'hBF);
      $display("t_rsvd done");
    end
  endtask
  // Clock enable low: a write is ignored and the pins hold
  task t_hold;
    begin
      @(posedge clk);
      ce <= 1'b0;
      host.write_byte(8'h02, 8'h3F);
      repeat (2) @(posedge clk);
      #1 chk("frozen pins", 8'h20, pins(8'h02));
      @(posedge clk);
      ce <= 1'b1;
      get(8'h02, 8'h20);
      $display("t_hold done");
    end
  endtask
  // Mid-run reset: pins show defaults during reset and after release
  task t_rst;
    begin
      @(posedge clk);
      rstn <= 1'b0;
      romDividerN <= 7'h00;
      repeat (3) @(posedge clk);
      #1;
      for (k = 2; k < 8; k = k + 1) begin
        if (k != 6) chk("reset pins", want(k[7:0], DFLT[8*k-16 +: 8]), pins(k[7:0]));
      end
      @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      #1 t_defaults;
      $display("t_rst done");
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 t_defaults;
    t_stop;
    t_rate;
    t_codes;
    $display("t_codes done");
    t_mode;
    t_div;
    t_rsvd;
    t_hold;
    t_rst;
    print_verdict;
  end
endmodule
